// >>> logic/pmwh_regs.svh
`ifndef PMWH_REGS_SVH
`define PMWH_REGS_SVH
// ----------------------------------------
// timing, in ns as printed, and rounding
// ----------------------------------------
`define PMWH_CLK_NS      5
`define PMWH_LMAX_NS     200
`define PMWH_LMIN_NS     40
`define PMWH_DHC_NS      250
`define PMWH_DH_NS       250
`define PMWH_BYTE_NS     86806
`define PMWH_CYC_UP(ns)  (((ns) + `PMWH_CLK_NS - 1) / `PMWH_CLK_NS)
`define PMWH_TIMER_W     16
// ----------------------------------------
// command frames: opcode, p0, p1
// ----------------------------------------
`define PMWH_OP_SCAN     8'h10
`define PMWH_OP_TLDIS    8'h20
`define PMWH_OP_NVS      8'h30
`define PMWH_NVS_SYS_ADR 8'h62
`define PMWH_NVS_XTAL_B  1
`define PMWH_FRAME_LAST  2'h2
// ----------------------------------------
// event bytes
// ----------------------------------------
`define PMWH_EV_TLDIS    8'hA0
`define PMWH_EV_TLEN     8'hA1
`define PMWH_EV_LINK     8'hA2
`define PMWH_EV_DATA     8'hA3
`define PMWH_EV_END      8'h03
// ----------------------------------------
// host software registers
// ----------------------------------------
`define PMWH_HREG_CMD    2'h0
`define PMWH_HREG_WAKE   2'h1
`define PMWH_HREG_STAT   2'h2
`endif

// >>> logic/pmwh_pkg.sv
package pmwh_pkg;
  typedef enum logic [5:0] {
    deep_sleep_mode    = 6'h01,
    command_idle_mode  = 6'h02,
    standby_scan_mode  = 6'h04,
    boot_default_mode  = 6'h08,
    linked_sleep_mode  = 6'h10,
    full_activity_mode = 6'h20
  } pmwh_mode_t;
  typedef enum logic [5:0] {
    ds_flow      = 6'h01,
    ds_cfm       = 6'h02,
    ds_redef     = 6'h04,
    ds_sleep     = 6'h08,
    ds_wake_host = 6'h10,
    ds_tx_ev     = 6'h20
  } pmwh_dst_t;
  typedef enum logic [3:0] {
    hs_awake   = 4'h1,
    hs_holdoff = 4'h2,
    hs_sleep   = 4'h4,
    hs_waking  = 4'h8
  } pmwh_hst_t;
endpackage

// >>> logic/pmwh_if.sv
`timescale 1ns/1ps
// ----------------------------------------
// null-modem link: each rts feeds the other side's cts
// ----------------------------------------
interface pmwh_if;
  logic       dev_rts;
  logic       host_rts;
  logic       d2h_valid;
  logic [7:0] d2h_data;
  logic       h2d_valid;
  logic [7:0] h2d_data;
  modport dev_mp  (output dev_rts, d2h_valid, d2h_data,
                   input  host_rts, h2d_valid, h2d_data);
  modport host_mp (output host_rts, h2d_valid, h2d_data,
                   input  dev_rts, d2h_valid, d2h_data);
endinterface

// >>> logic/pmwh_delay.sv
`timescale 1ns/1ps
// ----------------------------------------
// one-shot down counter, done pulses when count_in cycles have passed
// ----------------------------------------
module pmwh_delay #(
  parameter int unsigned W = 16
) (
  // clock and reset
  input  wire logic         clk_in,
  input  wire logic         rst_n_in,
  // control
  input  wire logic         start_in,
  input  wire logic [W-1:0] count_in,
  // status
  output logic              busy_out,
  output logic              done_out
);
  typedef struct packed {
    logic [W-1:0] cnt;
    logic         busy;
    logic         done;
  } pmwh_dly_t;
  pmwh_dly_t s_r;
  pmwh_dly_t s_nxt;

  always_comb begin
    s_nxt      = s_r;
    s_nxt.done = 1'b0;
    if (start_in) begin
      s_nxt.cnt  = count_in;
      s_nxt.busy = 1'b1;
    end else if (s_r.busy) begin
      s_nxt.cnt = s_r.cnt - 1'b1;
      if (s_r.cnt <= W'(1)) begin
        s_nxt.busy = 1'b0;
        s_nxt.done = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign busy_out = s_r.busy;
  assign done_out = s_r.done;
endmodule

// >>> logic/pmwh_device.sv
// Notes on behaviour
// - six modes from uart and radio state
// - lines: flow control on, wake-up when off
// - boot into boot_default_mode, scanning on
// - link with uart on gives full_activity_mode
// - scan command zero/zero stops scanning
// - scan off and no link, then disable reaches deep sleep
// - transport disable accepted while the uart runs, except during confirm
// - disable stops interpreter and idle hardware
// - standby scan: incoming link wakes host
// - linked sleep: link or data wakes host
// - crystal setting off, enabled by bit cleared
// - crystal gates radio off between scans in standby scan only
// - confirm first, then lines become wake-up
// - lines cross-wired, device rts wakes host
// - host watches its cts for wake
// - wake-up use idles high, falling edge wakes
// - last confirm byte out before role change
// - cts becomes wake input after redefine delay
// - host waits holdoff before its first wake
// - host wake answered by enabled, then pending
// - host silent until transport-enabled event
`timescale 1ns/1ps
`include "pmwh_regs.svh"
module pmwh_device #(
  parameter int unsigned TW       = `PMWH_TIMER_W,
  parameter int unsigned DHC_CYC  = `PMWH_CYC_UP(`PMWH_DHC_NS),
  parameter int unsigned BYTE_CYC = `PMWH_CYC_UP(`PMWH_BYTE_NS)
) (
  // clock and reset
  input  wire logic          CORE_CLK_IN,
  input  wire logic          RST_N_IN,
  // radio events
  input  wire logic          LINK_UP_IN,
  input  wire logic          LINK_DOWN_IN,
  input  wire logic          RX_DATA_IN,
  input  wire logic          XTAL_FITTED_IN,
  // host link
  pmwh_if.dev_mp             LINK,
  // power status
  output pmwh_pkg::pmwh_mode_t MODE_OUT,
  output logic               UART_ON_OUT,
  output logic               DISCOVER_OUT,
  output logic               CONNECT_OUT,
  output logic               RADIO_GAP_OFF_OUT,
  output logic               XTAL_USE_OUT
);
  import pmwh_pkg::*;

  typedef struct packed {
    pmwh_mode_t      mode;
    pmwh_dst_t       st;
    logic            uart_en;
    logic            disc;
    logic            conn;
    logic            link;
    logic            xtal_nvs;
    logic            xtal_use;
    logic            radio_gap;
    logic            cts_prev;
    logic            rts;
    logic            pend;
    logic            tx_valid;
    logic [7:0]      tx_data;
    logic [3:0][7:0] tx_buf;
    logic [2:0]      tx_idx;
    logic [2:0]      tx_len;
    logic [1:0]      rx_idx;
    logic [7:0]      rx_op;
    logic [7:0]      rx_p0;
  } pmwh_dev_t;

  pmwh_dev_t s_r;
  pmwh_dev_t s_nxt;
  logic      dhc_start;
  logic      dhc_done;
  logic      byte_start;
  logic      byte_busy;
  logic      tx_fin;
  logic      wake_evt;
  logic      cts_fall;

  // ----------------------------------------
  // mode table
  // ----------------------------------------
  function automatic pmwh_mode_t mode_of(input logic uart, input logic lnk,
                                         input logic scan);
    mode_of = uart ? boot_default_mode : standby_scan_mode;
    if (lnk) begin
      mode_of = uart ? full_activity_mode : linked_sleep_mode;
    end else if (!scan) begin
      mode_of = uart ? command_idle_mode : deep_sleep_mode;
    end
  endfunction

  // ----------------------------------------
  // timers
  // ----------------------------------------
  pmwh_delay #(.W(TW)) u_dhc (
    .clk_in   (CORE_CLK_IN),
    .rst_n_in (RST_N_IN),
    .start_in (dhc_start),
    .count_in (TW'(DHC_CYC)),
    .busy_out (),
    .done_out (dhc_done)
  );

  // models the shift time of one byte on the wire
  pmwh_delay #(.W(TW)) u_byte (
    .clk_in   (CORE_CLK_IN),
    .rst_n_in (RST_N_IN),
    .start_in (byte_start),
    .count_in (TW'(BYTE_CYC)),
    .busy_out (byte_busy),
    .done_out ()
  );

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    s_nxt          = s_r;
    s_nxt.tx_valid = 1'b0;
    s_nxt.cts_prev = LINK.host_rts;
    dhc_start      = 1'b0;
    byte_start     = 1'b0;
    tx_fin   = (s_r.tx_idx == s_r.tx_len) && !byte_busy && !s_r.tx_valid;
    cts_fall = s_r.cts_prev && !LINK.host_rts;
    wake_evt = ((s_r.mode == standby_scan_mode) && LINK_UP_IN)
            || ((s_r.mode == linked_sleep_mode) && (LINK_UP_IN || RX_DATA_IN));

    if (LINK_UP_IN) begin
      s_nxt.link = 1'b1;
    end else if (LINK_DOWN_IN) begin
      s_nxt.link = 1'b0;
    end

    // a single pending cause is kept; the newest wins
    if (wake_evt) begin
      s_nxt.pend      = 1'b1;
      s_nxt.tx_buf[2] = LINK_UP_IN ? `PMWH_EV_LINK : `PMWH_EV_DATA;
      s_nxt.tx_buf[3] = `PMWH_EV_END;
    end

    // frames are only heard while the interpreter runs
    // still heard while pending events drain: the host may talk once enabled is seen
    if (s_r.uart_en && (s_r.st != ds_cfm) && LINK.h2d_valid) begin
      unique case (s_r.rx_idx)
        2'h0: begin
          s_nxt.rx_op  = LINK.h2d_data;
          s_nxt.rx_idx = 2'h1;
        end
        2'h1: begin
          s_nxt.rx_p0  = LINK.h2d_data;
          s_nxt.rx_idx = `PMWH_FRAME_LAST;
        end
        default: begin
          s_nxt.rx_idx = 2'h0;
          if (s_r.rx_op == `PMWH_OP_SCAN) begin
            s_nxt.disc = (s_r.rx_p0 != 8'h00);
            s_nxt.conn = (LINK.h2d_data != 8'h00);
          end else if ((s_r.rx_op == `PMWH_OP_NVS)
                    && (s_r.rx_p0 == `PMWH_NVS_SYS_ADR)) begin
            s_nxt.xtal_nvs = !LINK.h2d_data[`PMWH_NVS_XTAL_B];
          end else if (s_r.rx_op == `PMWH_OP_TLDIS) begin
            s_nxt.tx_buf[0] = `PMWH_EV_TLDIS;
            s_nxt.tx_buf[1] = `PMWH_EV_END;
            s_nxt.tx_idx    = 3'h0;
            s_nxt.tx_len    = 3'h2;
            s_nxt.st        = ds_cfm;
          end
        end
      endcase
    end

    // ----------------------------------------
    // byte sender, paced by cts while the uart runs
    // ----------------------------------------
    if ((s_r.tx_idx != s_r.tx_len) && !byte_busy && !s_r.tx_valid
        && s_r.uart_en && !LINK.host_rts) begin
      s_nxt.tx_valid = 1'b1;
      s_nxt.tx_data  = s_r.tx_buf[s_r.tx_idx[1:0]];
      s_nxt.tx_idx   = s_r.tx_idx + 3'h1;
      byte_start     = 1'b1;
    end

    // ----------------------------------------
    // line role sequencing
    // ----------------------------------------
    unique case (s_r.st)
      ds_flow: begin
        s_nxt.rts = 1'b0;
      end
      ds_cfm: begin
        if (tx_fin) begin
          s_nxt.uart_en = 1'b0;
          s_nxt.rts     = 1'b1;
          s_nxt.pend    = 1'b0;
          dhc_start     = 1'b1;
          s_nxt.st      = ds_redef;
        end
      end
      ds_redef: begin
        // cts is ambiguous here and is not looked at
        if (dhc_done) begin
          s_nxt.st = ds_sleep;
        end
      end
      ds_sleep: begin
        if (cts_fall) begin
          s_nxt.uart_en   = 1'b1;
          s_nxt.rts       = 1'b0;
          s_nxt.tx_buf[0] = `PMWH_EV_TLEN;
          s_nxt.tx_buf[1] = `PMWH_EV_END;
          s_nxt.tx_idx    = 3'h0;
          s_nxt.tx_len    = (s_r.pend || wake_evt) ? 3'h4 : 3'h2;
          s_nxt.pend      = 1'b0;
          s_nxt.st        = ds_tx_ev;
        end else if (s_r.pend) begin
          s_nxt.rts = 1'b0;
          s_nxt.st  = ds_wake_host;
        end
      end
      ds_wake_host: begin
        // host answers by returning its rts to ready
        if (!LINK.host_rts) begin
          s_nxt.uart_en   = 1'b1;
          s_nxt.tx_buf[0] = `PMWH_EV_TLEN;
          s_nxt.tx_buf[1] = `PMWH_EV_END;
          s_nxt.tx_idx    = 3'h0;
          s_nxt.tx_len    = 3'h4;
          s_nxt.pend      = 1'b0;
          s_nxt.st        = ds_tx_ev;
        end
      end
      ds_tx_ev: begin
        if (tx_fin && (s_nxt.st == ds_tx_ev)) begin
          s_nxt.st = ds_flow;
        end
      end
    endcase

    s_nxt.mode = mode_of(s_nxt.uart_en, s_nxt.link, s_nxt.disc || s_nxt.conn);
    s_nxt.xtal_use  = s_nxt.xtal_nvs && XTAL_FITTED_IN;
    s_nxt.radio_gap = s_nxt.xtal_use && (s_nxt.mode == standby_scan_mode);
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------
  always_ff @(posedge CORE_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      s_r          <= '0;
      s_r.mode     <= boot_default_mode;
      s_r.st       <= ds_flow;
      s_r.uart_en  <= 1'b1;
      s_r.disc     <= 1'b1;
      s_r.conn     <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign LINK.dev_rts       = s_r.rts;
  assign LINK.d2h_valid     = s_r.tx_valid;
  assign LINK.d2h_data      = s_r.tx_data;
  assign MODE_OUT           = s_r.mode;
  assign UART_ON_OUT        = s_r.uart_en;
  assign DISCOVER_OUT       = s_r.disc;
  assign CONNECT_OUT        = s_r.conn;
  assign RADIO_GAP_OFF_OUT  = s_r.radio_gap;
  assign XTAL_USE_OUT       = s_r.xtal_use;
endmodule

// >>> logic/pmwh_host.sv
`timescale 1ns/1ps
`include "pmwh_regs.svh"
module pmwh_host #(
  parameter int unsigned TW       = `PMWH_TIMER_W,
  parameter int unsigned DH_CYC   = `PMWH_CYC_UP(`PMWH_DH_NS),
  parameter int unsigned BYTE_CYC = `PMWH_CYC_UP(`PMWH_BYTE_NS)
) (
  // clock and reset
  input  wire logic        CORE_CLK_IN,
  input  wire logic        RST_N_IN,
  // software port
  input  wire logic [1:0]  ADDR_IN,
  input  wire logic [31:0] WDATA_IN,
  input  wire logic        WR_IN,
  input  wire logic        RD_IN,
  output logic [31:0]      RDATA_OUT,
  // device link
  pmwh_if.host_mp          LINK
);
  import pmwh_pkg::*;

  typedef struct packed {
    pmwh_hst_t       st;
    logic            rts;
    logic            tl_ok;
    logic            wake_req;
    logic            cts_prev;
    logic            tx_valid;
    logic [7:0]      tx_data;
    logic [2:0][7:0] tx_buf;
    logic [1:0]      tx_idx;
    logic [1:0]      tx_len;
    logic [7:0]      prev;
    logic [7:0]      last_evt;
    logic [31:0]     rdata;
  } pmwh_hos_t;

  pmwh_hos_t s_r;
  pmwh_hos_t s_nxt;
  logic      dh_start;
  logic      dh_done;
  logic      byte_start;
  logic      byte_busy;
  logic      busy;

  pmwh_delay #(.W(TW)) u_dh (
    .clk_in   (CORE_CLK_IN),
    .rst_n_in (RST_N_IN),
    .start_in (dh_start),
    // the last byte is only fully received one byte time after its pulse
    .count_in (TW'(DH_CYC + BYTE_CYC)),
    .busy_out (),
    .done_out (dh_done)
  );

  pmwh_delay #(.W(TW)) u_byte (
    .clk_in   (CORE_CLK_IN),
    .rst_n_in (RST_N_IN),
    .start_in (byte_start),
    .count_in (TW'(BYTE_CYC)),
    .busy_out (byte_busy),
    .done_out ()
  );

  always_comb begin
    s_nxt          = s_r;
    s_nxt.tx_valid = 1'b0;
    s_nxt.rdata    = 32'h0000_0000;
    s_nxt.cts_prev = LINK.dev_rts;
    dh_start       = 1'b0;
    byte_start     = 1'b0;
    busy           = (s_r.tx_idx != s_r.tx_len) || byte_busy || s_r.tx_valid;

    // ----------------------------------------
    // software port
    // ----------------------------------------
    if (WR_IN && (ADDR_IN == `PMWH_HREG_CMD) && !busy) begin
      s_nxt.tx_buf = WDATA_IN[23:0];
      s_nxt.tx_idx = 2'h0;
      s_nxt.tx_len = 2'h3;
    end
    if (WR_IN && (ADDR_IN == `PMWH_HREG_WAKE)) begin
      s_nxt.wake_req = 1'b1;
    end
    if (RD_IN && (ADDR_IN == `PMWH_HREG_STAT)) begin
      s_nxt.rdata = {18'h0, s_r.last_evt, s_r.st, s_r.tl_ok, busy};
    end

    // commands wait for ready cts and the enabled event
    if ((s_r.tx_idx != s_r.tx_len) && !byte_busy && !s_r.tx_valid && s_r.tl_ok
        && (s_r.st == hs_awake) && !LINK.dev_rts) begin
      s_nxt.tx_valid = 1'b1;
      s_nxt.tx_data  = s_r.tx_buf[s_r.tx_idx];
      s_nxt.tx_idx   = s_r.tx_idx + 2'h1;
      byte_start     = 1'b1;
    end

    // ----------------------------------------
    // event receiver
    // ----------------------------------------
    if (LINK.d2h_valid) begin
      s_nxt.prev = LINK.d2h_data;
      if (LINK.d2h_data == `PMWH_EV_END) begin
        s_nxt.last_evt = s_r.prev;
        if (s_r.prev == `PMWH_EV_TLDIS) begin
          s_nxt.rts   = 1'b1;
          s_nxt.tl_ok = 1'b0;
          s_nxt.st    = hs_holdoff;
          dh_start    = 1'b1;
        end else if (s_r.prev == `PMWH_EV_TLEN) begin
          s_nxt.tl_ok = 1'b1;
          s_nxt.st    = hs_awake;
        end
      end
    end

    // ----------------------------------------
    // wake-up lines
    // ----------------------------------------
    unique case (s_r.st)
      hs_awake: ;
      hs_holdoff: begin
        if (dh_done) begin
          s_nxt.st = hs_sleep;
        end
      end
      hs_sleep: begin
        if ((s_r.cts_prev && !LINK.dev_rts) || s_r.wake_req) begin
          s_nxt.rts      = 1'b0;
          s_nxt.wake_req = 1'b0;
          s_nxt.st       = hs_waking;
        end
      end
      hs_waking: ;
    endcase
  end

  always_ff @(posedge CORE_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      s_r          <= '0;
      s_r.st       <= hs_awake;
      s_r.tl_ok    <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign LINK.host_rts  = s_r.rts;
  assign LINK.h2d_valid = s_r.tx_valid;
  assign LINK.h2d_data  = s_r.tx_data;
  assign RDATA_OUT      = s_r.rdata;
endmodule

// >>> dv/pmwh_assertions.sv
`timescale 1ns/1ps
`include "pmwh_regs.svh"
module pmwh_assertions #(
  parameter int BYTE_CYC = 8
) (
  // clock and reset
  input wire logic                 CORE_CLK_IN,
  input wire logic                 RST_N_IN,
  // link wires
  input wire logic                 dev_rts,
  input wire logic                 host_rts,
  input wire logic                 d2h_valid,
  input wire logic [7:0]           d2h_data,
  input wire logic                 h2d_valid,
  input wire logic [7:0]           h2d_data,
  // device status
  input wire pmwh_pkg::pmwh_mode_t MODE_OUT,
  input wire logic                 UART_ON_OUT
);
  import pmwh_pkg::*;
  // ----------------------------------------
  // wake answer window, a few byte times
  // ----------------------------------------
  localparam int WAKE_WIN = 4 * BYTE_CYC + 8;
  default clocking cb @(posedge CORE_CLK_IN); endclocking
  default disable iff (!RST_N_IN);
  AST_BOOT_MODE: assert property (
    !$past(RST_N_IN) |-> MODE_OUT == boot_default_mode && UART_ON_OUT && !dev_rts)
    else $error("state after reset wrong");
  AST_MODE_MAP: assert property (
    $onehot(MODE_OUT) && (UART_ON_OUT ==
    (MODE_OUT inside {command_idle_mode, boot_default_mode, full_activity_mode})))
    else $error("mode and uart state disagree");
  AST_D2H_FLOW: assert property (
    d2h_valid |-> UART_ON_OUT && !host_rts)
    else $error("event byte sent without flow permission");
  AST_H2D_FLOW: assert property (
    h2d_valid |-> !dev_rts)
    else $error("command byte sent while device not ready");
  AST_D2H_GAP: assert property (
    d2h_valid |=> !d2h_valid [*8])
    else $error("event bytes too close");
  AST_H2D_GAP: assert property (
    h2d_valid |=> !h2d_valid [*8])
    else $error("command bytes too close");
  AST_CFM_HOLD: assert property (
    d2h_valid && d2h_data == `PMWH_EV_TLDIS |=> UART_ON_OUT [*8])
    else $error("uart dropped before confirm finished");
  AST_ROLE_SWAP: assert property (
    $rose(dev_rts) |-> $fell(UART_ON_OUT))
    else $error("rts raised apart from leaving flow control");
  AST_WAKE_LOW: assert property (
    $fell(dev_rts) |-> !$past(UART_ON_OUT))
    else $error("rts fell while uart was on");
  AST_HOST_HOLD: assert property (
    $rose(host_rts) |-> host_rts [*4])
    else $error("host wake before holdoff");
  AST_TLEN_FIRST: assert property (
    $fell(host_rts) && !UART_ON_OUT |->
    !h2d_valid throughout ##[1:WAKE_WIN] (d2h_valid && d2h_data == `PMWH_EV_TLEN))
    else $error("wake not answered by enabled event first");
endmodule

// >>> dv/power_mode_wake_handshake_tb.sv
`timescale 1ns/1ps
`include "pmwh_regs.svh"
module power_mode_wake_handshake_tb;
  import pmwh_pkg::*;
  localparam int unsigned BYTE_CYC = 8;
  localparam int unsigned GAP_CYC  = 4;
  // ----------------------------------------
  // stimulus and observed signals
  // ----------------------------------------
  logic        core_clk = 1'h0;
  logic        rst_n    = 1'h0;
  logic [2:0]  radio_ev = 3'h0;
  logic        xtal_fit = 1'h1;
  logic [1:0]  addr     = 2'h0;
  logic [31:0] wdata    = 32'h0;
  logic        wr       = 1'h0;
  logic        rd       = 1'h0;
  logic [31:0] rdata;
  pmwh_mode_t  mode;
  logic        uart_on, discover, connect, gap_off, xtal_use;
  logic [4:0]  flags;
  int          errors   = 0;
  int          checked  = 0;
  int          cycles   = 0;
  assign flags = {uart_on, discover, connect, gap_off, xtal_use};
  pmwh_if link ();
  pmwh_device #(.DHC_CYC(GAP_CYC), .BYTE_CYC(BYTE_CYC)) u_pmwh_device (
    .CORE_CLK_IN(core_clk), .RST_N_IN(rst_n), .LINK_UP_IN(radio_ev[0]),
    .LINK_DOWN_IN(radio_ev[1]), .RX_DATA_IN(radio_ev[2]), .XTAL_FITTED_IN(xtal_fit),
    .LINK(link.dev_mp), .MODE_OUT(mode), .UART_ON_OUT(uart_on), .DISCOVER_OUT(discover),
    .CONNECT_OUT(connect), .RADIO_GAP_OFF_OUT(gap_off), .XTAL_USE_OUT(xtal_use));
  pmwh_host #(.DH_CYC(GAP_CYC), .BYTE_CYC(BYTE_CYC)) u_pmwh_host (
    .CORE_CLK_IN(core_clk), .RST_N_IN(rst_n), .ADDR_IN(addr), .WDATA_IN(wdata),
    .WR_IN(wr), .RD_IN(rd), .RDATA_OUT(rdata), .LINK(link.host_mp));
  pmwh_assertions #(.BYTE_CYC(BYTE_CYC)) u_pmwh_assertions (
    .CORE_CLK_IN(core_clk), .RST_N_IN(rst_n), .dev_rts(link.dev_rts),
    .host_rts(link.host_rts), .d2h_valid(link.d2h_valid), .d2h_data(link.d2h_data),
    .h2d_valid(link.h2d_valid), .h2d_data(link.h2d_data), .MODE_OUT(mode),
    .UART_ON_OUT(uart_on));
  initial begin
    forever #2.5 core_clk = ~core_clk;
  end
  // ----------------------------------------
  // shared tasks: every driver starts on an edge
  // ----------------------------------------
  task automatic test_done();
    $display("errors %0d checked %0d", errors, checked);
    if (errors == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr_reg(input logic [1:0] a, input logic [31:0] d);
    @(posedge core_clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'h1;
    @(posedge core_clk);
    wr    <= 1'h0;
  endtask
  task automatic rd_reg(input logic [1:0] a, output logic [31:0] v);
    @(posedge core_clk);
    addr <= a;
    rd   <= 1'h1;
    @(posedge core_clk);
    rd   <= 1'h0;
    #1 v = rdata;
  endtask
  // status polled until the masked field matches, then judged
  task automatic wait_stat(input logic [31:0] mask, input logic [31:0] val);
    logic [31:0] v;
    int          n;
    n = 0;
    rd_reg(`PMWH_HREG_STAT, v);
    while ((v & mask) !== val && n < 400) begin
      rd_reg(`PMWH_HREG_STAT, v);
      n++;
    end
    chk("status", val, v & mask);
  endtask
  task automatic send_cmd(input logic [7:0] op, input logic [7:0] p0, input logic [7:0] p1);
    wr_reg(`PMWH_HREG_CMD, {8'h00, p1, p0, op});
    wait_stat(32'h1, 32'h0);
  endtask
  task automatic wait_dev(input pmwh_mode_t m, input logic [4:0] f);
    int n;
    n = 0;
    @(posedge core_clk);
    #1;
    while ((mode !== m || flags !== f) && n < 600) begin
      @(posedge core_clk);
      #1;
      n++;
    end
    chk("mode", m, mode);
    chk("flags", f, flags);
  endtask
  task automatic pulse_ev(input logic [2:0] e);
    @(posedge core_clk);
    radio_ev <= e;
    @(posedge core_clk);
    radio_ev <= 3'h0;
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset();
    logic [31:0] v;
    chk("mode", boot_default_mode, mode);
    chk("flags", 5'h1C, flags);
    rd_reg(`PMWH_HREG_STAT, v);
    chk("status", 32'h6, v & 32'h3F);
    rd_reg(2'h3, v);
    chk("unmapped", 32'h0, v);
  endtask
  task automatic t_link();
    pulse_ev(3'h1);
    wait_dev(full_activity_mode, 5'h1C);
    pulse_ev(3'h2);
    wait_dev(boot_default_mode, 5'h1C);
  endtask
  task automatic t_scan_xtal();
    send_cmd(`PMWH_OP_SCAN, 8'h00, 8'h00);
    wait_dev(command_idle_mode, 5'h10);
    send_cmd(`PMWH_OP_NVS, `PMWH_NVS_SYS_ADR, 8'h00);
    wait_dev(command_idle_mode, 5'h11);
    send_cmd(`PMWH_OP_NVS, `PMWH_NVS_SYS_ADR, 8'h02);
    wait_dev(command_idle_mode, 5'h10);
    send_cmd(`PMWH_OP_NVS, `PMWH_NVS_SYS_ADR, 8'h00);
    wait_dev(command_idle_mode, 5'h11);
    @(posedge core_clk);
    xtal_fit <= 1'h0;
    wait_dev(command_idle_mode, 5'h10);
    @(posedge core_clk);
    xtal_fit <= 1'h1;
    wait_dev(command_idle_mode, 5'h11);
    send_cmd(`PMWH_OP_SCAN, 8'h01, 8'h01);
    wait_dev(boot_default_mode, 5'h1D);
  endtask
  // disable from scanning, then an incoming link wakes the host
  task automatic t_standby();
    send_cmd(`PMWH_OP_TLDIS, 8'h00, 8'h00);
    wait_dev(standby_scan_mode, 5'h0F);
    chk("dev rts", 1'h1, link.dev_rts);
    wait_stat(32'h3E, 32'h10);
    pulse_ev(3'h1);
    wait_dev(full_activity_mode, 5'h1D);
    wait_stat(32'h3FFE, 32'h2886);
  endtask
  task automatic t_linked();
    send_cmd(`PMWH_OP_TLDIS, 8'h00, 8'h00);
    wait_dev(linked_sleep_mode, 5'h0D);
    wait_stat(32'h3E, 32'h10);
    pulse_ev(3'h4);
    wait_dev(full_activity_mode, 5'h1D);
    wait_stat(32'h3FFE, 32'h28C6);
  endtask
  // deep sleep, woken from the host side
  task automatic t_deep();
    pulse_ev(3'h2);
    wait_dev(boot_default_mode, 5'h1D);
    send_cmd(`PMWH_OP_SCAN, 8'h00, 8'h00);
    wait_dev(command_idle_mode, 5'h11);
    send_cmd(`PMWH_OP_TLDIS, 8'h00, 8'h00);
    wait_dev(deep_sleep_mode, 5'h01);
    wait_stat(32'h3E, 32'h10);
    wr_reg(`PMWH_HREG_WAKE, 32'h0);
    wait_dev(command_idle_mode, 5'h11);
    wait_stat(32'h3FFE, 32'h2846);
  endtask
  // ----------------------------------------
  // hang guard and main sequence
  // ----------------------------------------
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      errors++;
      test_done();
    end
  end
  initial begin
    repeat (6) @(posedge core_clk);
    rst_n <= 1'h1;
    t_reset();
    t_link();
    t_scan_xtal();
    t_standby();
    t_linked();
    t_deep();
    test_done();
  end
endmodule
